// ===== sa6pi_pkg.sv
// Constants shared by the national bit six pattern-change interrupt logic
package sa6pi_pkg;

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_MATCH_NOW = 8'h02;

    // ------------------------------------------------------------
    // Field layout: pattern index i lives at register bit i + PAT_LSB
    // ------------------------------------------------------------
    localparam int NUM_PAT = 6;
    localparam int PAT_LSB = 2;
    localparam int BIT_ALL_ONES = 7;
    localparam int BIT_1110 = 6;
    localparam int BIT_1100 = 5;
    localparam int BIT_1010 = 4;
    localparam int BIT_1000 = 3;
    localparam int BIT_001X = 2;

    // Reset values
    localparam logic [DATA_W-1:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [DATA_W-1:0] RST_IRQ_STATUS = 8'h00;
    localparam logic [DATA_W-1:0] RST_READ_DATA = 8'h00;
    localparam logic [NUM_PAT-1:0] RST_PAT_FLAGS = 6'h00;

    // ------------------------------------------------------------
    // Patterns, index 0 = bit 2 (001x) up to index 5 = bit 7 (1111)
    // ------------------------------------------------------------
    typedef logic [NUM_PAT-1:0][3:0] sa6pi_pat_tab_t;

    localparam sa6pi_pat_tab_t PAT_VALUE = {4'hf, 4'he, 4'hc, 4'ha, 4'h8, 4'h2};
    localparam sa6pi_pat_tab_t PAT_CARE = {4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'he};

endpackage

// ===== sa6pi_evt_if.sv
// Interface between the register hub and the pattern match tracker
`timescale 1ns/100ps
`default_nettype none

interface sa6pi_evt_if;
    import sa6pi_pkg::*;

    logic [3:0] nibble;          // Debounced national bit six nibble
    logic [NUM_PAT-1:0] match;   // Registered match state per pattern
    logic [NUM_PAT-1:0] change;  // One-cycle pulse on entry or exit

    modport tracker (
        input nibble,
        output match,
        output change
    );

    modport hub (
        output nibble,
        input match,
        input change
    );

endinterface

`default_nettype wire

// ===== sa6pi_match_tracker.sv
// Pattern match tracker: detects entry into and exit from each pattern
`timescale 1ns/100ps
`default_nettype none

module sa6pi_match_tracker #(
    parameter int NPAT = sa6pi_pkg::NUM_PAT  // Number of tracked patterns
) (
    input wire logic mclk,              // Register clock
    input wire logic rstn,              // Asynchronous reset, active low
    sa6pi_evt_if.tracker evt            // Nibble in, match and change out
);
    import sa6pi_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NPAT != NUM_PAT) begin : g_bad_npat
        $error("sa6pi_match_tracker: NPAT must equal the pattern table size");
    end

    logic [NUM_PAT-1:0] hit;
    logic [NUM_PAT-1:0] match;
    logic [NUM_PAT-1:0] change;
    logic primed;
    logic [NUM_PAT-1:0] next_match;
    logic [NUM_PAT-1:0] next_change;
    logic next_primed;

    // ------------------------------------------------------------
    // Compare against each pattern; cleared care bits are ignored
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PAT; i++) begin : g_cmp
        assign hit[i] = ((evt.nibble ^ PAT_VALUE[i]) & PAT_CARE[i]) == 4'h0;
    end

    // Both edges of a match produce a change pulse; the first sample after
    // reset only loads the history so a standing value is not reported
    always_comb begin
        next_match = hit;
        next_primed = 1'b1;
        next_change = primed ? (hit ^ match) : RST_PAT_FLAGS;
    end

    // History and pulse registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            match <= RST_PAT_FLAGS;
            change <= RST_PAT_FLAGS;
            primed <= 1'b0;
        end else begin
            match <= next_match;
            change <= next_change;
            primed <= next_primed;
        end
    end

    assign evt.match = match;
    assign evt.change = change;

endmodule

`default_nettype wire

// ===== sa6pi_irq_enable.sv
// National bit six pattern-change interrupt enable, status and request logic
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module sa6pi_irq_enable (
    input wire logic mclk,                                // Register clock, 125 MHz
    input wire logic rstn,                                // Asynchronous reset, active low
    input wire logic [3:0] nibbleIn,                      // Debounced nibble, same clock
    input wire logic [sa6pi_pkg::ADDR_W-1:0] regAddr,     // Register address
    input wire logic [sa6pi_pkg::DATA_W-1:0] regWrData,   // Register write data
    input wire logic regWr,                               // Write strobe, one cycle
    input wire logic regRd,                               // Read strobe, one cycle
    output logic [sa6pi_pkg::DATA_W-1:0] regRdData,       // Read data, cycle after strobe
    output logic irq                                      // Interrupt request, active high
);
    import sa6pi_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sa6pi_evt_if evt ();

    logic [NUM_PAT-1:0] enable;
    logic [NUM_PAT-1:0] status;
    logic [NUM_PAT-1:0] next_enable;
    logic [NUM_PAT-1:0] next_status;
    logic [DATA_W-1:0] next_regRdData;
    logic next_irq;

    logic selEnable;
    logic selStatus;
    logic selMatch;
    logic [NUM_PAT-1:0] wrField;
    logic [NUM_PAT-1:0] statusEvent;
    logic [NUM_PAT-1:0] statusClear;

    // ------------------------------------------------------------
    // Pattern tracker
    // ------------------------------------------------------------

    // The nibble comes from the framer's debounce logic on mclk, so it
    // needs no synchroniser here
    assign evt.nibble = nibbleIn;

    sa6pi_match_tracker #(
        .NPAT(NUM_PAT)
    ) u_tracker (
        .mclk(mclk),
        .rstn(rstn),
        .evt(evt)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Full address compare; anything unmapped reads zero and ignores writes
    assign selEnable = (regAddr == OFS_IRQ_ENABLE);
    assign selStatus = (regAddr == OFS_IRQ_STATUS);
    assign selMatch = (regAddr == OFS_MATCH_NOW);

    // Pattern field of the write data, bits 7 down to 2
    assign wrField = regWrData[PAT_LSB +: NUM_PAT];

    // ------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------

    // Bits 7..2 are read/write and clear to 0; bits 1..0 are not
    // implemented by this block and read back as zero
    always_comb begin
        next_enable = enable;
        if (regWr && selEnable) begin
            next_enable[BIT_ALL_ONES - PAT_LSB] = wrField[BIT_ALL_ONES - PAT_LSB];
            next_enable[BIT_1110 - PAT_LSB] = wrField[BIT_1110 - PAT_LSB];
            next_enable[BIT_1100 - PAT_LSB] = wrField[BIT_1100 - PAT_LSB];
            next_enable[BIT_1010 - PAT_LSB] = wrField[BIT_1010 - PAT_LSB];
            next_enable[BIT_1000 - PAT_LSB] = wrField[BIT_1000 - PAT_LSB];
            next_enable[BIT_001X - PAT_LSB] = wrField[BIT_001X - PAT_LSB];
        end
    end

    // Enable flops; reset value 0 keeps every pattern quiet at start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enable <= RST_IRQ_ENABLE[PAT_LSB +: NUM_PAT];
        end else begin
            enable <= next_enable;
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------

    // Only enabled patterns record their change events, so a disabled
    // pattern can neither set status nor raise the request
    assign statusEvent = evt.change & enable;

    // Reading the status register clears it; writing ones also clears
    // the chosen bits, for software that prefers explicit acknowledge
    always_comb begin
        statusClear = RST_PAT_FLAGS;
        if (regRd && selStatus) begin
            statusClear = ~RST_PAT_FLAGS;
        end else if (regWr && selStatus) begin
            statusClear = wrField;
        end
    end

    // A change landing in the clearing cycle survives: set wins over clear
    always_comb begin
        next_status = (status & ~statusClear) | statusEvent;
    end

    // Sticky status flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status <= RST_IRQ_STATUS[PAT_LSB +: NUM_PAT];
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------

    // Read data is captured on the strobe and stands only in the next
    // cycle; the status value returned is the one before the clear
    always_comb begin
        next_regRdData = RST_READ_DATA;
        if (regRd) begin
            if (selEnable) begin
                next_regRdData[PAT_LSB +: NUM_PAT] = enable;
            end else if (selStatus) begin
                next_regRdData[PAT_LSB +: NUM_PAT] = status;
            end else if (selMatch) begin
                next_regRdData[PAT_LSB +: NUM_PAT] = evt.match;
            end
        end
    end

    // Read data flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= RST_READ_DATA;
        end else begin
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------

    // Built from the next values so the output flop lines up with the
    // status and enable flops: no extra cycle of stale request after a
    // clear or after software drops an enable
    always_comb begin
        next_irq = |(next_status & next_enable);
    end

    // Request flop, level output
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

endmodule

`default_nettype wire

// ===== sa6pi_irq_asserts.sv
// Port-level checks for the national bit six pattern-change interrupt block
`timescale 1ns/100ps
`default_nettype none
module sa6pi_irq_asserts (
    input wire logic mclk, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic [3:0] nibbleIn, // Nibble
    input wire logic [sa6pi_pkg::ADDR_W-1:0] regAddr, // Address
    input wire logic [sa6pi_pkg::DATA_W-1:0] regWrData, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [sa6pi_pkg::DATA_W-1:0] regRdData, // Read data
    input wire logic irq // Request
);
    import sa6pi_pkg::*;
    logic [7:0] shadowEn;
    logic [5:0] hit;
    logic [5:0] prevHit;
    logic evt;
    logic evtD1;
    logic evtD2;
    // ----
    // Shadow of the enables and match history
    // ----
    always_comb begin
        for (int i = 0; i < NUM_PAT; i++) begin
            hit[i] = (nibbleIn & PAT_CARE[i]) == PAT_VALUE[i];
        end
    end
    assign evt = |(hit ^ prevHit);
    // Reset history is zero, so a false event only narrows the checks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shadowEn <= 8'h00;
            prevHit <= 6'h00;
            evtD1 <= 1'h0;
            evtD2 <= 1'h0;
        end else begin
            if (regWr && regAddr == OFS_IRQ_ENABLE) begin
                shadowEn <= regWrData & 8'hfc;
            end
            prevHit <= hit;
            evtD1 <= evt;
            evtD2 <= evtD1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not zero after idle cycle");
    en_echo_a: assert property (regRd && regAddr == OFS_IRQ_ENABLE
        |=> regRdData == $past(shadowEn)) else $error("enable readback wrong");
    unmapped_rd_a: assert property (regRd && regAddr > OFS_MATCH_NOW
        |=> regRdData == 8'h00) else $error("unmapped read not zero");
    low_bits_a: assert property (regRdData[1:0] == 2'h0)
        else $error("unused low bits set");
    irq_off_a: assert property (shadowEn == 8'h00 && $past(shadowEn) == 8'h00
        |-> !irq) else $error("request while all disabled");
    // An enable write in the two cycles after the change may legally drop it
    evt_irq_a: assert property (|((hit ^ prevHit) & shadowEn[7:2])
        && !(regWr && regAddr == OFS_IRQ_ENABLE)
        ##1 !(regWr && regAddr == OFS_IRQ_ENABLE) |-> ##1 irq)
        else $error("enabled change gave no request");
    rd_clear_a: assert property (regRd && regAddr == OFS_IRQ_STATUS
        && !evt && !evtD1 && !evtD2 |=> !irq) else $error("status read left request");
    irq_hold_a: assert property (irq && !regWr
        && !(regRd && regAddr == OFS_IRQ_STATUS) |=> irq) else $error("request dropped");
    cover property ($rose(irq));
    cover property (irq ##1 regRd && regAddr == OFS_IRQ_STATUS);
    cover property (regRd && regAddr > OFS_MATCH_NOW);
endmodule
bind sa6pi_irq_enable sa6pi_irq_asserts u_chk (.mclk(mclk), .rstn(rstn),
    .nibbleIn(nibbleIn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irq(irq));
`default_nettype wire

// ===== sa6pi_irq_enable_tb_top.sv
// Self-checking bench for the national bit six pattern-change interrupt block
`timescale 1ns/100ps
`default_nettype none
module sa6pi_irq_enable_tb_top;
    import sa6pi_pkg::*;
    logic mclk, rstn, regWr, regRd, irq;
    logic [3:0] nibbleIn;
    logic [7:0] regAddr, regWrData, regRdData;
    int n_fail, comparisons;
    sa6pi_irq_enable dut (.mclk(mclk), .rstn(rstn), .nibbleIn(nibbleIn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq));
    // ----
    // Bus and compare helpers
    // ----
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'h0;
    endtask
    // Data stands one cycle only, so sample mid-cycle
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'h0;
        @(negedge mclk);
        check(regRdData, exp);
    endtask
    // Request lags a new nibble by two edges; four leaves margin
    task automatic nib(input logic [3:0] v, input logic expIrq);
        @(posedge mclk);
        nibbleIn <= v;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check({7'h00, irq}, {7'h00, expIrq});
    endtask
    task automatic resetAndRw();
        rdChk(OFS_IRQ_ENABLE, 8'h00);
        rdChk(OFS_IRQ_STATUS, 8'h00);
        rdChk(8'h7f, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'hff);
        rdChk(OFS_IRQ_ENABLE, 8'hfc);
        wr(OFS_IRQ_ENABLE, 8'h00);
        wr(8'h40, 8'hff);
        rdChk(OFS_IRQ_ENABLE, 8'h00);
    endtask
    task automatic patternSweep();
        logic [3:0] entry [6] = '{4'h3, 4'h8, 4'ha, 4'hc, 4'he, 4'hf};
        logic [7:0] bitv;
        for (int i = 0; i < 6; i++) begin
            bitv = 8'h04 << i;
            wr(OFS_IRQ_ENABLE, bitv);
            nib(entry[i], 1'h1);
            rdChk(OFS_MATCH_NOW, bitv);
            rdChk(OFS_IRQ_STATUS, bitv);
            rdChk(OFS_IRQ_STATUS, 8'h00);
            check({7'h00, irq}, 8'h00);
            nib(4'h5, 1'h1);
            rdChk(OFS_IRQ_STATUS, bitv);
            rdChk(OFS_MATCH_NOW, 8'h00);
            wr(OFS_IRQ_ENABLE, 8'h00);
            nib(entry[i], 1'h0);
            rdChk(OFS_MATCH_NOW, bitv);
            nib(4'h5, 1'h0);
            rdChk(OFS_IRQ_STATUS, 8'h00);
        end
    endtask
    // Leaving one pattern for another must flag both
    task automatic crossAndMask();
        wr(OFS_IRQ_ENABLE, 8'hc0);
        nib(4'hf, 1'h1);
        rdChk(OFS_IRQ_STATUS, 8'h80);
        nib(4'he, 1'h1);
        rdChk(OFS_IRQ_STATUS, 8'hc0);
        nib(4'h5, 1'h1);
        wr(OFS_IRQ_ENABLE, 8'h00);
        @(negedge mclk);
        check({7'h00, irq}, 8'h00);
        rdChk(OFS_IRQ_STATUS, 8'h40);
        // Write-one clear: a zero bit leaves the request, a one drops it
        wr(OFS_IRQ_ENABLE, 8'h80);
        nib(4'hf, 1'h1);
        wr(OFS_IRQ_STATUS, 8'h40);
        @(negedge mclk);
        check({7'h00, irq}, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h80);
        @(negedge mclk);
        check({7'h00, irq}, 8'h00);
        rdChk(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        rstn = 1'h0;
        regWr = 1'h0;
        regRd = 1'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        nibbleIn = 4'h5;
        n_fail = 0;
        comparisons = 0;
        repeat (4) @(posedge mclk);
        rstn <= 1'h1;
        resetAndRw();
        patternSweep();
        crossAndMask();
        tally_and_finish();
    end
endmodule
`default_nettype wire
